/* hdl/ltx_cfg.svh */
// widths, field codes, chip mode codes and timing counts for the transceiver control
`ifndef LTX_CFG_SVH
`define LTX_CFG_SVH
`define LTX_NUM          3
`define LTX_CLK_MHZ      50
`define LTX_MODE_OFF     2'h0
`define LTX_MODE_WAKE    2'h1
`define LTX_MODE_RXONLY  2'h2
`define LTX_MODE_NORMAL  2'h3
`define LTX_CHIP_NORMAL  3'h0
`define LTX_CHIP_STOP    3'h1
`define LTX_CHIP_SLEEP   3'h2
`define LTX_CHIP_RESTART 3'h3
`define LTX_CHIP_FAILSAFE 3'h4
`define LTX_EN_DELAY_US  10
`define LTX_WAKE_FILT_US 30
`define LTX_DOM_TO_US    12000
`define LTX_EN_CYC       (`LTX_EN_DELAY_US * `LTX_CLK_MHZ)
`define LTX_WAKE_CYC     (`LTX_WAKE_FILT_US * `LTX_CLK_MHZ)
`define LTX_DOM_TO_CYC   (`LTX_DOM_TO_US * `LTX_CLK_MHZ)
`define LTX_CNT_W        20
`define LTX_EVT_W        3
`define LTX_EVT_KIND_BIT 2
`define LTX_FIFO_DEPTH   16
`endif

/* hdl/ltx_ctrl.sv */
// single-wire bus transceiver mode, wake and time-out control for three channels
`timescale 1ns/10ps
`include "ltx_cfg.svh"
module ltx_ctrl
  import ltx_pkg::*;
#(
  parameter int EN_CYC   = `LTX_EN_CYC,
  parameter int WAKE_CYC = `LTX_WAKE_CYC,
  parameter int TO_CYC   = `LTX_DOM_TO_CYC
) (
  input  wire logic       i_clk,                   // 50 MHz internal oscillator
  input  wire logic       i_resetn,                // power-up reset, active low
  input  wire logic [2:0] i_chip_mode,             // current chip mode
  input  wire logic       i_chip_mode_cmd,         // pulse: chip mode commanded
  input  wire logic [2:0] i_mode_wr,               // pulse per transceiver: write mode
  input  wire logic [1:0] i_mode_wdata,            // mode value to write
  input  wire logic       i_tx_timeout_disable,    // disables transmit time-out
  input  wire logic       i_low_slope_select,      // requested slope
  input  wire logic       i_cs_n,                  // chip select pin
  input  wire logic       i_watchdog_on_bus_wake,  // re-enable watchdog on wake
  input  wire logic       i_watchdog_enabled,      // watchdog currently enabled
  input  wire logic       i_supply_uv,             // transceiver supply undervoltage
  input  wire logic [2:0] i_tx_data_in,            // transmit data pins
  input  wire logic [2:0] i_bus_rx,                // received bus level, 1 recessive
  input  wire logic [2:0] i_fault_clr,             // pulse: clear fault flags
  input  wire logic [2:0] i_wake_clr,              // pulse: clear wake status bits
  output logic      [2:0] o_bus_drive_dom,         // 1 drives bus dominant
  output logic      [2:0] o_rx_data_out,           // receive data pins
  output logic      [1:0] o_transceiver_mode_field_1, // mode field 1
  output logic      [1:0] o_transceiver_mode_field_2, // mode field 2
  output logic      [1:0] o_transceiver_mode_field_3, // mode field 3
  output logic      [2:0] o_wake_status_reg_two,   // wake source bits
  output logic      [2:0] o_transceiver_fault,     // fault flags
  output logic      [2:0] o_bus_status_one,        // transmit time-out status
  output logic      [2:0] o_bus_status_two,        // transmit time-out status
  output logic            o_int_n,                 // interrupt, active low
  output logic            o_restart_req,           // pulse: move chip to Restart
  output logic            o_watchdog_reenable,     // pulse: enable watchdog
  output logic            o_low_slope,             // effective slope
  output logic            o_evt_valid,             // event word valid
  output logic      [2:0] o_evt_data,              // {kind, transceiver}
  input  wire logic       i_evt_ready              // event word taken
);
  localparam int NS = 8;
  localparam logic [`LTX_CNT_W-1:0] EN_C = EN_CYC[`LTX_CNT_W-1:0];
  localparam logic [`LTX_CNT_W-1:0] WK_C = WAKE_CYC[`LTX_CNT_W-1:0];
  localparam logic [`LTX_CNT_W-1:0] TO_C = TO_CYC[`LTX_CNT_W-1:0];

  // three-flop synchronisers; a change is taken when flops two and three agree
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [NS-1:0] pin_q;
  logic [NS-1:0] pin_raw;

  assign pin_raw = {i_cs_n, i_supply_uv, i_tx_data_in, i_bus_rx};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // every stage starts at the idle pin levels so no false edge follows reset
      s1_q  <= 8'hbf;
      s2_q  <= 8'hbf;
      s3_q  <= 8'hbf;
      pin_q <= 8'hbf;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int k = 0; k < NS; k++)
        if (s2_q[k] == s3_q[k]) pin_q[k] <= s3_q[k];
    end
  end

  logic       cs_n_q;
  logic       uv_q;
  logic [2:0] tx_q;
  logic [2:0] bus_q;
  assign bus_q = pin_q[2:0];
  assign tx_q  = pin_q[5:3];
  assign uv_q  = pin_q[6];
  assign cs_n_q = pin_q[7];

  // chip mode history for entry detection
  logic [2:0] chip_prev_q;
  logic       rearm;
  logic       fs_entry;
  logic       chip_nrm;
  logic       chip_stp;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) chip_prev_q <= `LTX_CHIP_NORMAL;
    else chip_prev_q <= i_chip_mode;
  end

  assign chip_nrm = (i_chip_mode == `LTX_CHIP_NORMAL);
  assign chip_stp = (i_chip_mode == `LTX_CHIP_STOP);
  assign fs_entry = (i_chip_mode == `LTX_CHIP_FAILSAFE) && (chip_prev_q != `LTX_CHIP_FAILSAFE);
  assign rearm = ((i_chip_mode != chip_prev_q) &&
                  (chip_stp || i_chip_mode == `LTX_CHIP_SLEEP || fs_entry)) ||
                 (i_chip_mode_cmd && chip_stp);

  // slope change waits for the end of the serial frame
  logic cs_n_d1_q;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_n_d1_q   <= 1'b1;
      o_low_slope <= 1'b0;
    end else begin
      cs_n_d1_q <= cs_n_q;
      if (cs_n_q && !cs_n_d1_q && chip_nrm) o_low_slope <= i_low_slope_select;
    end
  end

  logic [1:0] mode_q [3];
  logic [2:0] wake_ev;
  logic [2:0] fault_ev;
  logic [2:0] woken;

  assign o_transceiver_mode_field_1 = mode_q[0];
  assign o_transceiver_mode_field_2 = mode_q[1];
  assign o_transceiver_mode_field_3 = mode_q[2];

  genvar g;
  generate
    for (g = 0; g < `LTX_NUM; g++) begin : g_trx
      logic                  wr_ok;
      logic                  mode_chg;
      logic [`LTX_CNT_W-1:0] en_cnt_q;
      logic                  en_done_q;
      logic                  armed_q;
      logic [`LTX_CNT_W-1:0] txl_cnt_q;
      logic                  tx_to_q;
      logic [`LTX_CNT_W-1:0] busl_cnt_q;
      logic [`LTX_CNT_W-1:0] dom_cnt_q;
      ltx_wake_type          wk_q;
      logic                  rx_act;

      always_comb begin
        case (i_mode_wdata)
          `LTX_MODE_NORMAL: wr_ok = chip_nrm;
          `LTX_MODE_RXONLY: wr_ok = chip_nrm || chip_stp;
          `LTX_MODE_WAKE:   wr_ok = (i_chip_mode <= `LTX_CHIP_RESTART);
          default:          wr_ok = 1'b1;
        endcase
      end

      assign mode_chg = i_mode_wr[g] && wr_ok;

      // mode field is only changed by writes or fail-safe entry, never by undervoltage
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) mode_q[g] <= `LTX_MODE_OFF;
        else if (fs_entry) mode_q[g] <= `LTX_MODE_WAKE;
        else if (mode_chg) mode_q[g] <= i_mode_wdata;
      end

      // enabling delay, then a recessive input must be seen before a dominant is sent
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          en_cnt_q  <= '0;
          en_done_q <= 1'b0;
          armed_q   <= 1'b0;
        end else if (mode_q[g] != `LTX_MODE_NORMAL || mode_chg) begin
          en_cnt_q  <= '0;
          en_done_q <= 1'b0;
          armed_q   <= 1'b0;
        end else if (!en_done_q) begin
          en_cnt_q <= en_cnt_q + 1'b1;
          if (en_cnt_q >= EN_C - 1'b1) en_done_q <= 1'b1;
        end else if (tx_q[g]) begin
          armed_q <= 1'b1;
        end
      end

      // transmit dominant time-out; stage comes back once the input is recessive
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          txl_cnt_q <= '0;
          tx_to_q   <= 1'b0;
        end else if (tx_q[g] || i_tx_timeout_disable) begin
          txl_cnt_q <= '0;
          tx_to_q   <= 1'b0;
        end else if (txl_cnt_q < TO_C) begin
          txl_cnt_q <= txl_cnt_q + 1'b1;
        end else begin
          tx_to_q <= 1'b1;
        end
      end

      assign rx_act = (mode_q[g] == `LTX_MODE_NORMAL) || (mode_q[g] == `LTX_MODE_RXONLY);

      // bus clamping watch, only while reception is active
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) busl_cnt_q <= '0;
        else if (bus_q[g] || !rx_act) busl_cnt_q <= '0;
        else if (busl_cnt_q <= TO_C) busl_cnt_q <= busl_cnt_q + 1'b1;
      end

      assign fault_ev[g] = (!tx_to_q && !tx_q[g] && !i_tx_timeout_disable && txl_cnt_q == TO_C)
                        || (rx_act && !bus_q[g] && busl_cnt_q == TO_C);

      // wake detector: needs recessive, then long dominant, then release
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          wk_q      <= WK_WAIT_REC;
          dom_cnt_q <= '0;
        end else if (mode_q[g] != `LTX_MODE_WAKE || mode_chg || rearm) begin
          wk_q      <= WK_WAIT_REC;
          dom_cnt_q <= '0;
        end else begin
          case (wk_q)
            WK_WAIT_REC: if (bus_q[g]) wk_q <= WK_REC;
            WK_REC: begin
              dom_cnt_q <= '0;
              if (!bus_q[g]) wk_q <= WK_DOM;
            end
            WK_DOM: begin
              if (dom_cnt_q <= WK_C) dom_cnt_q <= dom_cnt_q + 1'b1;
              if (bus_q[g]) wk_q <= (dom_cnt_q > WK_C) ? WK_WOKEN : WK_REC;
            end
            WK_WOKEN: wk_q <= WK_WOKEN;
            default: wk_q <= WK_WAIT_REC;
          endcase
        end
      end

      assign woken[g]   = (wk_q == WK_WOKEN);
      assign wake_ev[g] = (wk_q == WK_DOM) && bus_q[g] && (dom_cnt_q > WK_C) &&
                          (mode_q[g] == `LTX_MODE_WAKE) && !mode_chg && !rearm;

      // undervoltage and time-out only gate the driver
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) o_bus_drive_dom[g] <= 1'b0;
        else o_bus_drive_dom[g] <= (mode_q[g] == `LTX_MODE_NORMAL) && en_done_q &&
                                   armed_q && !tx_q[g] && !tx_to_q && !uv_q;
      end

      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) o_rx_data_out[g] <= 1'b1;
        else if (woken[g] || wake_ev[g]) o_rx_data_out[g] <= 1'b0;
        else if (rx_act) o_rx_data_out[g] <= bus_q[g];
        else o_rx_data_out[g] <= 1'b1;
      end

      // status flags: a new event wins over a clear in the same cycle
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_transceiver_fault[g] <= 1'b0;
          o_bus_status_one[g]    <= 1'b0;
          o_bus_status_two[g]    <= 1'b0;
        end else begin
          if (fault_ev[g]) o_transceiver_fault[g] <= 1'b1;
          else if (i_fault_clr[g]) o_transceiver_fault[g] <= 1'b0;
          if (tx_to_q == 1'b0 && !tx_q[g] && !i_tx_timeout_disable && txl_cnt_q == TO_C) begin
            o_bus_status_one[g] <= 1'b1;
            o_bus_status_two[g] <= 1'b1;
          end else if (i_fault_clr[g]) begin
            o_bus_status_one[g] <= 1'b0;
            o_bus_status_two[g] <= 1'b0;
          end
        end
      end

      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) o_wake_status_reg_two[g] <= 1'b0;
        else if (wake_ev[g]) o_wake_status_reg_two[g] <= 1'b1;
        else if (i_wake_clr[g]) o_wake_status_reg_two[g] <= 1'b0;
      end
    end
  endgenerate

  // chip-level reaction to a wake
  logic any_wake;
  logic int_pend_q;
  assign any_wake = |wake_ev;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      int_pend_q          <= 1'b0;
      o_int_n             <= 1'b1;
      o_restart_req       <= 1'b0;
      o_watchdog_reenable <= 1'b0;
    end else begin
      if (any_wake && (chip_nrm || chip_stp)) int_pend_q <= 1'b1;
      else if (|i_wake_clr) int_pend_q <= 1'b0;
      o_int_n       <= !(int_pend_q || (any_wake && (chip_nrm || chip_stp)));
      o_restart_req <= any_wake && !chip_nrm && !chip_stp;
      o_watchdog_reenable <= any_wake && chip_stp && !i_watchdog_enabled &&
                             i_watchdog_on_bus_wake;
    end
  end

  // event records wait in pending flags until the buffer has room
  logic [5:0]            pend_q;
  logic [5:0]            pend_set;
  logic                  fifo_rdy;
  logic                  push;
  logic [`LTX_EVT_W-1:0] push_data;
  logic [5:0]            pick;

  assign pend_set = {fault_ev, wake_ev};

  always_comb begin
    pick      = '0;
    push_data = '0;
    push      = 1'b0;
    for (int k = 5; k >= 0; k--) begin
      if (pend_q[k]) begin
        pick      = 6'h01 << k;
        push_data = {k[`LTX_EVT_KIND_BIT] | (k >= 3), 2'((k >= 3) ? k - 3 : k)};
        push      = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) pend_q <= '0;
    else pend_q <= (pend_q & ~(fifo_rdy ? pick : 6'h00)) | pend_set;
  end

  ltx_fifo #(
    .WIDTH (`LTX_EVT_W),
    .DEPTH (`LTX_FIFO_DEPTH)
  ) u_evt_fifo (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_valid  (push),
    .i_data   (push_data),
    .o_ready  (fifo_rdy),
    .o_valid  (o_evt_valid),
    .o_data   (o_evt_data),
    .i_ready  (i_evt_ready)
  );
endmodule : ltx_ctrl

/* hdl/ltx_fifo.sv */
// event buffer with registered head, valid/ready on both sides
`timescale 1ns/10ps
module ltx_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,     // system clock
  input  wire logic             i_resetn,  // async reset, active low
  input  wire logic             i_valid,   // write request
  input  wire logic [WIDTH-1:0] i_data,    // write data
  output logic                  o_ready,   // space available
  output logic                  o_valid,   // head valid
  output logic      [WIDTH-1:0] o_data,    // head word
  input  wire logic             i_ready    // reader takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push  = i_valid && o_ready;
  assign pop   = o_valid && i_ready;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      o_valid <= 1'b0;
      o_ready <= 1'b1;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q   <= cnt_d;
      o_valid <= (cnt_d != '0);
      o_ready <= (cnt_d != DEPTH[AW:0]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem_q[wr_q] <= i_data;
  end

  // head is kept in its own flop so the reader sees a registered word
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data <= '0;
    end else if (!o_valid || pop) begin
      if (cnt_q == {{AW{1'b0}}, pop})
        o_data <= i_data;
      else if (pop)
        o_data <= mem_q[rd_q + 1'b1];
      else
        o_data <= mem_q[rd_q];
    end
  end
endmodule : ltx_fifo

/* hdl/ltx_pkg.sv */
// types shared by the transceiver control and its bench
package ltx_pkg;
  typedef logic [1:0] ltx_mode_type;
  typedef logic [2:0] ltx_chip_type;
  typedef enum logic [1:0] {
    WK_WAIT_REC,
    WK_REC,
    WK_DOM,
    WK_WOKEN
  } ltx_wake_type;
endpackage : ltx_pkg

/* verif/ltx_ctrl_bench.sv */
// self-checking bench for the transceiver mode, wake and time-out control
`timescale 1ns/10ps
module ltx_ctrl_bench
  import ltx_pkg::*;
;
  ltx_chip_type chip = 3'h0;
  logic       i_clk = 1'b0, i_resetn = 1'b0, cmd = 1'b0, to_dis = 1'b0, lss = 1'b0;
  logic       cs_n = 1'b1, wd_bit = 1'b1, wd_en = 1'b0, uv = 1'b0, rdy = 1'b1;
  logic [2:0] wr = 3'h0, fclr = 3'h0, wclr = 3'h0, bus_ext = 3'h7;
  logic [2:0] drv, rx, tx, wst, flt, bs1, bs2, evd;
  logic [1:0] wd = 2'h0, f1, f2, f3;
  logic       int_n, rst_req, wdre, low_slope, evv, rst_seen = 1'b0, wdre_seen = 1'b0;
  int         failures = 0, check_count = 0;
  wire  [2:0] bus_rx = bus_ext & ~drv;
  always #10 i_clk = ~i_clk;
  // pulses last one cycle, so keep a sticky copy for later comparison
  always @(posedge i_clk) begin
    if (rst_req) rst_seen <= 1'b1;
    if (wdre) wdre_seen <= 1'b1;
  end
  ltx_ctrl #(.EN_CYC(4), .WAKE_CYC(8), .TO_CYC(20)) DUT (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_chip_mode(chip), .i_chip_mode_cmd(cmd),
    .i_mode_wr(wr), .i_mode_wdata(wd), .i_tx_timeout_disable(to_dis),
    .i_low_slope_select(lss), .i_cs_n(cs_n), .i_watchdog_on_bus_wake(wd_bit),
    .i_watchdog_enabled(wd_en), .i_supply_uv(uv), .i_tx_data_in(tx), .i_bus_rx(bus_rx),
    .i_fault_clr(fclr), .i_wake_clr(wclr), .o_bus_drive_dom(drv), .o_rx_data_out(rx),
    .o_transceiver_mode_field_1(f1), .o_transceiver_mode_field_2(f2),
    .o_transceiver_mode_field_3(f3), .o_wake_status_reg_two(wst),
    .o_transceiver_fault(flt), .o_bus_status_one(bs1), .o_bus_status_two(bs2),
    .o_int_n(int_n), .o_restart_req(rst_req), .o_watchdog_reenable(wdre),
    .o_low_slope(low_slope), .o_evt_valid(evv), .o_evt_data(evd), .i_evt_ready(rdy));
  ltx_mcu_model #(.EN_CYC(4)) mcu (.i_clk(i_clk), .i_rx(rx), .o_tx(tx));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  task automatic wmode(input logic [2:0] sel, input logic [1:0] m);
    @(posedge i_clk);
    wr <= sel;
    wd <= m;
    @(posedge i_clk);
    wr <= 3'h0;
  endtask : wmode
  task automatic setchip(input logic [2:0] m);
    @(posedge i_clk);
    chip <= m;
    cmd <= 1'b1;
    @(posedge i_clk);
    cmd <= 1'b0;
  endtask : setchip
  task automatic clr_all();
    @(posedge i_clk);
    fclr <= 3'h7;
    wclr <= 3'h7;
    @(posedge i_clk);
    fclr <= 3'h0;
    wclr <= 3'h0;
  endtask : clr_all
  task automatic wake_bus();
    @(posedge i_clk);
    bus_ext[0] <= 1'b0;
    cyc(14);
    bus_ext[0] <= 1'b1;
    cyc(7);
  endtask : wake_bus
  task automatic t_modes();
    logic ok;
    for (int c = 0; c < 4; c++) begin
      for (int m = 1; m < 4; m++) begin
        setchip(c[2:0]);
        wmode(3'h3, 2'h0);
        wmode(3'h3, m[1:0]);
        cyc(1);
        ok = (m == 1) || (m == 2 && c < 2) || (c == 0);
        chk(f2, ok ? m[1:0] : 2'h0);
        chk(f1, ok ? m[1:0] : 2'h0);
      end
    end
  endtask : t_modes
  task automatic t_tx();
    setchip(3'h0);
    mcu.set_tx(3'h1, 1'b0);
    wmode(3'h1, 2'h3);
    cyc(12);
    chk(drv[0], 1'b0);
    mcu.set_tx(3'h1, 1'b1);
    cyc(6);
    mcu.set_tx(3'h1, 1'b0);
    cyc(12);
    chk({drv[0], mcu.rx_q[0]}, 2'h2);
    mcu.set_tx(3'h1, 1'b1);
    cyc(12);
    chk({drv[0], mcu.rx_q[0]}, 2'h1);
  endtask : t_tx
  task automatic t_timeout();
    wmode(3'h1, 2'h0);
    wmode(3'h1, 2'h3);
    mcu.enable_wait();
    mcu.set_tx(3'h1, 1'b0);
    cyc(30);
    chk({drv[0], flt[0], bs1[0], bs2[0]}, 4'h7);
    mcu.set_tx(3'h1, 1'b1);
    cyc(6);
    mcu.set_tx(3'h1, 1'b0);
    cyc(6);
    chk(drv[0], 1'b1);
    mcu.set_tx(3'h1, 1'b1);
    clr_all();
    to_dis <= 1'b1;
    mcu.set_tx(3'h1, 1'b0);
    cyc(30);
    chk({drv[0], bs1[0]}, 2'h2);
    mcu.set_tx(3'h1, 1'b1);
    to_dis <= 1'b0;
    cyc(6);
    clr_all();
  endtask : t_timeout
  task automatic t_uv();
    mcu.set_tx(3'h1, 1'b0);
    uv <= 1'b1;
    cyc(7);
    chk({drv[0], f1}, 3'h3);
    uv <= 1'b0;
    cyc(7);
    chk(drv[0], 1'b1);
    mcu.set_tx(3'h1, 1'b1);
    cyc(6);
  endtask : t_uv
  task automatic t_wake();
    wmode(3'h5, 2'h1);
    cyc(4);
    @(posedge i_clk);
    bus_ext[0] <= 1'b0;
    cyc(5);
    bus_ext[0] <= 1'b1;
    cyc(6);
    chk({wst[0], rx[0]}, 2'h1);
    wake_bus();
    chk({wst[0], rx[0], int_n, f1}, 5'h11);
    clr_all();
    setchip(3'h1);
    cyc(6);
    chk(rx[0], 1'b1);
    wake_bus();
    chk({rx[0], int_n, wdre_seen}, 3'h1);
    setchip(3'h1);
    cyc(6);
    chk(rx[0], 1'b1);
    clr_all();
    setchip(3'h2);
    wake_bus();
    chk({rx[0], int_n, rst_seen}, 3'h3);
    setchip(3'h0);
    wmode(3'h1, 2'h2);
    wmode(3'h1, 2'h1);
    cyc(6);
    chk(rx[0], 1'b1);
    wmode(3'h4, 2'h0);
    setchip(3'h4);
    cyc(3);
    chk(f3, 2'h1);
    setchip(3'h0);
  endtask : t_wake
  task automatic t_slope();
    setchip(3'h1);
    lss <= 1'b1;
    cs_n <= 1'b0;
    cyc(3);
    cs_n <= 1'b1;
    cyc(8);
    chk(low_slope, 1'b0);
    setchip(3'h0);
    cs_n <= 1'b0;
    cyc(3);
    cs_n <= 1'b1;
    cyc(8);
    chk(low_slope, 1'b1);
  endtask : t_slope
  task automatic t_fifo();
    int n;
    n = 0;
    wmode(3'h7, 2'h2);
    rdy <= 1'b0;
    repeat (6) begin
      bus_ext <= 3'h0;
      cyc(30);
      chk({flt, f2, drv, rx}, 11'h780);
      bus_ext <= 3'h7;
      clr_all();
    end
    chk(evv, 1'b1);
    rdy <= 1'b1;
    repeat (40) begin
      @(posedge i_clk);
      if (evv === 1'b1 && rdy === 1'b1) begin
        n++;
        chk(evd[2], 1'b1);
      end
    end
    chk({evv, n >= 16}, 2'h1);
  endtask : t_fifo
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  initial begin
    cyc(3);
    chk({drv, f1, f2, f3, int_n, low_slope, rx}, 14'h0017);
    @(posedge i_clk);
    i_resetn <= 1'b1;
    cyc(4);
    t_modes();
    t_tx();
    t_timeout();
    t_uv();
    t_wake();
    t_slope();
    t_fifo();
    conclude();
  end
endmodule : ltx_ctrl_bench

/* verif/ltx_ctrl_sva.sv */
// concurrent checks on the transceiver control ports
`timescale 1ns/10ps
`include "ltx_cfg.svh"
module ltx_ctrl_sva (
  input wire logic       i_clk,                      // clock
  input wire logic       i_resetn,                   // reset, low
  input wire logic [2:0] i_chip_mode,                // chip mode
  input wire logic [2:0] i_mode_wr,                  // write pulses
  input wire logic [1:0] i_mode_wdata,               // mode value
  input wire logic       i_tx_timeout_disable,       // time-out off
  input wire logic       i_cs_n,                     // chip select
  input wire logic       i_supply_uv,                // undervoltage
  input wire logic [2:0] i_tx_data_in,               // transmit pins
  input wire logic [2:0] o_bus_drive_dom,            // driver
  input wire logic [2:0] o_rx_data_out,              // receive pins
  input wire logic [1:0] o_transceiver_mode_field_1, // field 1
  input wire logic [2:0] o_wake_status_reg_two,      // wake bits
  input wire logic [2:0] o_transceiver_fault,        // faults
  input wire logic [2:0] o_bus_status_one,           // status one
  input wire logic [2:0] o_bus_status_two,           // status two
  input wire logic       o_int_n,                    // interrupt
  input wire logic       o_restart_req,              // restart
  input wire logic       o_low_slope                 // slope
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire [1:0] f1 = o_transceiver_mode_field_1;
  off_no_drive_a: assert property (
    f1 == `LTX_MODE_OFF && $past(f1) == `LTX_MODE_OFF |-> !o_bus_drive_dom[0])
    else $error("driver active while off");
  drive_needs_normal_a: assert property (
    o_bus_drive_dom[0] |-> $past(f1) == `LTX_MODE_NORMAL)
    else $error("driver active outside normal mode");
  tx_high_release_a: assert property (
    i_tx_data_in[0] [*6] |-> !o_bus_drive_dom[0])
    else $error("driver held with transmit input high");
  uv_no_drive_a: assert property (
    i_supply_uv [*6] |-> o_bus_drive_dom == 3'h0)
    else $error("driver active in undervoltage");
  normal_refused_a: assert property (
    i_mode_wr[0] && i_mode_wdata == `LTX_MODE_NORMAL && f1 != `LTX_MODE_NORMAL
    && i_chip_mode != `LTX_CHIP_NORMAL |=> f1 != `LTX_MODE_NORMAL)
    else $error("normal mode taken outside chip normal");
  failsafe_wake_a: assert property (
    $rose(i_chip_mode == `LTX_CHIP_FAILSAFE) |-> ##[0:2] f1 == `LTX_MODE_WAKE)
    else $error("fail-safe entry did not force wake mode");
  wake_rx_low_a: assert property (
    $rose(o_wake_status_reg_two[0]) |-> !o_rx_data_out[0] && f1 == `LTX_MODE_WAKE)
    else $error("wake without low receive output");
  int_cause_a: assert property (
    $fell(o_int_n) |-> $past(i_chip_mode) <= `LTX_CHIP_STOP)
    else $error("interrupt in wrong chip mode");
  restart_cause_a: assert property (
    o_restart_req |-> $past(i_chip_mode) >= `LTX_CHIP_SLEEP && o_int_n == $past(o_int_n))
    else $error("restart request in wrong chip mode");
  txto_status_a: assert property (
    $rose(o_bus_status_one[0]) |-> o_bus_status_two[0] && o_transceiver_fault[0]
    && !$past(i_tx_timeout_disable))
    else $error("transmit time-out flags wrong");
  slope_cs_a: assert property (
    $changed(o_low_slope) |-> $past(i_cs_n) && $past(i_chip_mode) == `LTX_CHIP_NORMAL)
    else $error("slope changed without chip select rise");
  wake_c: cover property ($rose(o_wake_status_reg_two[0]));
  restart_c: cover property (o_restart_req);
  txto_c: cover property ($rose(o_bus_status_one[0]));
endmodule : ltx_ctrl_sva
bind ltx_ctrl ltx_ctrl_sva u_sva (.*);

/* verif/ltx_mcu_model.sv */
// controller side: drives the transmit pins and samples the receive pins
`timescale 1ns/10ps
module ltx_mcu_model #(
  parameter int EN_CYC = 4
) (
  input  wire logic       i_clk, // clock
  input  wire logic [2:0] i_rx,  // receive pins
  output logic      [2:0] o_tx   // transmit pins, pulled up when idle
);
  logic [2:0] rx_q = 3'h7;
  initial o_tx = 3'h7;
  always @(posedge i_clk) rx_q <= i_rx;
  task automatic set_tx(input logic [2:0] m, input logic v);
    @(posedge i_clk);
    o_tx <= v ? (o_tx | m) : (o_tx & ~m);
  endtask : set_tx
  // recessive through the enabling delay so no partial bit is sent
  task automatic enable_wait();
    @(posedge i_clk);
    o_tx <= 3'h7;
    repeat (EN_CYC + 4) @(posedge i_clk);
  endtask : enable_wait
endmodule : ltx_mcu_model
